// file: dtcu_pkg.sv
// Package for the dual timer/counter unit: offsets, fields, reset values.
// Assumes a single 200 MHz clock and an AHB-Lite register port.
package dtcu_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h88; // Run and flag control
  localparam logic [7:0] IDX_MODE = 8'h89; // Mode select
  localparam logic [7:0] IDX_FLO = 8'h8A; // First count low byte
  localparam logic [7:0] IDX_SLO = 8'h8B; // Second count low byte
  localparam logic [7:0] IDX_FHI = 8'h8C; // First count high byte
  localparam logic [7:0] IDX_SHI = 8'h8D; // Second count high byte
  localparam logic [7:0] IDX_PRESC = 8'h8F; // Prescaler select
  localparam logic [7:0] IDX_INV = 8'h90; // Trigger invert and service
  localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [9:0] ADDR_MODE = {IDX_MODE, 2'b00};
  localparam logic [9:0] ADDR_FLO = {IDX_FLO, 2'b00};
  localparam logic [9:0] ADDR_SLO = {IDX_SLO, 2'b00};
  localparam logic [9:0] ADDR_FHI = {IDX_FHI, 2'b00};
  localparam logic [9:0] ADDR_SHI = {IDX_SHI, 2'b00};
  localparam logic [9:0] ADDR_PRESC = {IDX_PRESC, 2'b00};
  localparam logic [9:0] ADDR_INV = {IDX_INV, 2'b00};
  // Control register fields
  localparam int CTRL_SOVF = 7;
  localparam int CTRL_SRUN = 6;
  localparam int CTRL_FOVF = 5;
  localparam int CTRL_FRUN = 4;
  localparam int CTRL_BFLAG = 3;
  localparam int CTRL_BTYPE = 2;
  localparam int CTRL_AFLAG = 1;
  localparam int CTRL_ATYPE = 0;
  // Mode register fields, per timer nibble (first at 0, second at 4)
  localparam int MODE_SECOND_BASE = 4;
  localparam int MODE_GATE = 3;
  localparam int MODE_CNT = 2;
  localparam int INV_BIT = 1;
  // Service register bits (write 1 = interrupt serviced)
  localparam int SVC_FOVF = 2;
  localparam int SVC_SOVF = 3;
  localparam int SVC_AFLAG = 4;
  localparam int SVC_BFLAG = 5;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [3:0] PRESC_RESET = 4'hF;
  // Mode codes
  localparam logic [1:0] MODE_13 = 2'h0;
  localparam logic [1:0] MODE_16 = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  // Prescaler codes and divide counts
  localparam logic [1:0] PS_DIV4 = 2'h1;
  localparam logic [1:0] PS_DIV8 = 2'h2;
  localparam logic [3:0] DIV4_LAST = 4'h3;
  localparam logic [3:0] DIV8_LAST = 4'h7;
  localparam logic [3:0] DIV12_LAST = 4'hB;
endpackage

// file: dtcu_prescaler.sv
// Prescaler tick generator for one timer of the dual timer/counter unit.
// Assumes synchronous active-high reset; code 00 is reserved, no ticks.
`timescale 1ns/1ps
module dtcu_prescaler (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [1:0] sel_i, // Divider select code
  output logic tick_o // One-cycle tick
);
  logic [3:0] cnt_reg;
  logic [3:0] last;

  // Terminal count from the select code
  always_comb begin
    case (sel_i)
      dtcu_pkg::PS_DIV4: last = dtcu_pkg::DIV4_LAST;
      dtcu_pkg::PS_DIV8: last = dtcu_pkg::DIV8_LAST;
      default: last = dtcu_pkg::DIV12_LAST;
    endcase
  end

  // Free-running divider; reserved code holds it still
  always_ff @(posedge clk_i) begin
    if (rst_i || sel_i == 2'h0) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg >= last) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  assign tick_o = (sel_i != 2'h0) && (cnt_reg >= last);

  chk_div_period: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_o && sel_i == dtcu_pkg::PS_DIV4 && $stable(sel_i))
      |=> (!tick_o && sel_i == dtcu_pkg::PS_DIV4)[*3] ##1 tick_o
      or ##[1:3] sel_i != dtcu_pkg::PS_DIV4)
    else $error("divide by 4 period wrong");
endmodule

// file: dtcu_top.sv
// Dual timer/counter unit with AHB-Lite register access.
// Assumes count and interrupt pins are synchronous to CLK_I.
`timescale 1ns/1ps
module dtcu_top (
  input wire logic CLK_I, // System clock
  input wire logic RST_I, // Synchronous reset, active high
  input wire logic HSEL_I, // Slave select
  input wire logic [31:0] HADDR_I, // Byte address
  input wire logic [1:0] HTRANS_I, // Transfer type
  input wire logic HWRITE_I, // Write strobe
  input wire logic [2:0] HSIZE_I, // Transfer size
  input wire logic [31:0] HWDATA_I, // Write data
  input wire logic HREADY_I, // Bus ready
  output logic [31:0] HRDATA_O, // Read data
  output logic HREADYOUT_O, // Slave ready
  output logic HRESP_O, // Always OKAY
  input wire logic FIRST_COUNT_INPUT_PIN_I, // First count input
  input wire logic SECOND_COUNT_INPUT_PIN_I, // Second count input
  input wire logic EXT_IRQ_A_PIN_I, // First ext interrupt and gate
  input wire logic EXT_IRQ_B_PIN_I, // Second ext interrupt and gate
  output logic FIRST_OVERFLOW_O, // First overflow flag
  output logic SECOND_OVERFLOW_O, // Second overflow flag
  output logic EXT_IRQ_A_O, // First ext flag
  output logic EXT_IRQ_B_O // Second ext flag
);
  logic [7:0] ctrl_reg;
  logic [7:0] mode_reg;
  logic [3:0] presc_reg;
  logic inv_reg;
  logic [7:0] flo_reg, fhi_reg, slo_reg, shi_reg;
  logic wr_pend_reg;
  logic [9:0] waddr_reg;
  logic [31:0] rdata_reg;
  logic fcnt_d_reg, scnt_d_reg, irqa_d_reg, irqb_d_reg;
  logic ftick, stick;
  logic wr_en;
  logic [7:0] wdat;
  logic fpin_fall, spin_fall, a_trig, b_trig;
  logic [1:0] fmode, smode;
  logic f_run, s_run, split_hi_run;
  logic f_ovf, s_ovf, hi_ovf;
  logic [7:0] flo_next, fhi_next, slo_next, shi_next;
  logic [1:0] svc_fovf, svc_sovf;

  // Two prescalers, one per timer
  dtcu_prescaler u_ps_first (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .sel_i(presc_reg[1:0]),
    .tick_o(ftick)
  );
  dtcu_prescaler u_ps_second (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .sel_i(presc_reg[3:2]),
    .tick_o(stick)
  );

  // Bus: zero wait states, OKAY always; write lands in data phase
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign wr_en = wr_pend_reg;
  assign wdat = HWDATA_I[7:0];
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      wr_pend_reg <= 1'b0;
      waddr_reg <= 10'h000;
    end else begin
      wr_pend_reg <= HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
      waddr_reg <= HADDR_I[9:0];
    end
  end

  // Read data registered at the address phase; unmapped reads zero
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rdata_reg <= 32'h0000_0000;
    end else if (HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I) begin
      case (HADDR_I[9:0])
        dtcu_pkg::ADDR_CTRL: rdata_reg <= {24'h000000, ctrl_reg};
        dtcu_pkg::ADDR_MODE: rdata_reg <= {24'h000000, mode_reg};
        dtcu_pkg::ADDR_FLO: rdata_reg <= {24'h000000, flo_reg};
        dtcu_pkg::ADDR_SLO: rdata_reg <= {24'h000000, slo_reg};
        dtcu_pkg::ADDR_FHI: rdata_reg <= {24'h000000, fhi_reg};
        dtcu_pkg::ADDR_SHI: rdata_reg <= {24'h000000, shi_reg};
        dtcu_pkg::ADDR_PRESC: rdata_reg <= {28'h0000000, presc_reg};
        dtcu_pkg::ADDR_INV: rdata_reg <= {30'h0, inv_reg, 1'b0};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign HRDATA_O = rdata_reg;

  // Pin history for edge detection
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      fcnt_d_reg <= 1'b0;
      scnt_d_reg <= 1'b0;
      irqa_d_reg <= 1'b0;
      irqb_d_reg <= 1'b0;
    end else begin
      fcnt_d_reg <= FIRST_COUNT_INPUT_PIN_I;
      scnt_d_reg <= SECOND_COUNT_INPUT_PIN_I;
      irqa_d_reg <= EXT_IRQ_A_PIN_I;
      irqb_d_reg <= EXT_IRQ_B_PIN_I;
    end
  end
  // Falling edge seen over two samples; caps rate at half the clock
  assign fpin_fall = fcnt_d_reg && !FIRST_COUNT_INPUT_PIN_I;
  assign spin_fall = scnt_d_reg && !SECOND_COUNT_INPUT_PIN_I;

  // Trigger select: edge or level, polarity flipped by invert bit
  always_comb begin
    if (ctrl_reg[dtcu_pkg::CTRL_ATYPE]) begin
      a_trig = inv_reg ? (!irqa_d_reg && EXT_IRQ_A_PIN_I)
                       : (irqa_d_reg && !EXT_IRQ_A_PIN_I);
    end else begin
      a_trig = inv_reg ? EXT_IRQ_A_PIN_I : !EXT_IRQ_A_PIN_I;
    end
    if (ctrl_reg[dtcu_pkg::CTRL_BTYPE]) begin
      b_trig = inv_reg ? (!irqb_d_reg && EXT_IRQ_B_PIN_I)
                       : (irqb_d_reg && !EXT_IRQ_B_PIN_I);
    end else begin
      b_trig = inv_reg ? EXT_IRQ_B_PIN_I : !EXT_IRQ_B_PIN_I;
    end
  end

  assign fmode = mode_reg[1:0];
  assign smode = mode_reg[5:4];

  // Count enables: run bit, gate, then tick or pin edge
  always_comb begin
    f_run = ctrl_reg[dtcu_pkg::CTRL_FRUN]
      && (!mode_reg[dtcu_pkg::MODE_GATE] || EXT_IRQ_A_PIN_I)
      && (mode_reg[dtcu_pkg::MODE_CNT] ? fpin_fall : ftick);
    s_run = ctrl_reg[dtcu_pkg::CTRL_SRUN]
      && (!mode_reg[dtcu_pkg::MODE_SECOND_BASE + dtcu_pkg::MODE_GATE]
          || EXT_IRQ_B_PIN_I)
      && (mode_reg[dtcu_pkg::MODE_SECOND_BASE + dtcu_pkg::MODE_CNT]
          ? spin_fall : stick)
      && (smode != dtcu_pkg::MODE_SPLIT);
    // Split high byte: timer only, second run bit
    split_hi_run = ctrl_reg[dtcu_pkg::CTRL_SRUN] && ftick;
  end

  // First timer next-state per mode
  always_comb begin
    flo_next = flo_reg;
    fhi_next = fhi_reg;
    f_ovf = 1'b0;
    hi_ovf = 1'b0;
    case (fmode)
      dtcu_pkg::MODE_13: begin
        flo_next = {3'h0, flo_reg[4:0]};
        if (f_run) begin
          {fhi_next, flo_next[4:0]} = {fhi_reg, flo_reg[4:0]} + 13'h1;
          f_ovf = (fhi_reg == 8'hFF) && (flo_reg[4:0] == 5'h1F);
        end
      end
      dtcu_pkg::MODE_16: begin
        if (f_run) begin
          {fhi_next, flo_next} = {fhi_reg, flo_reg} + 16'h1;
          f_ovf = {fhi_reg, flo_reg} == 16'hFFFF;
        end
      end
      dtcu_pkg::MODE_RELOAD: begin
        if (f_run) begin
          f_ovf = flo_reg == 8'hFF;
          flo_next = f_ovf ? fhi_reg : flo_reg + 8'h01;
        end
      end
      default: begin
        if (f_run) begin
          flo_next = flo_reg + 8'h01;
          f_ovf = flo_reg == 8'hFF;
        end
        if (split_hi_run) begin
          fhi_next = fhi_reg + 8'h01;
          hi_ovf = fhi_reg == 8'hFF;
        end
      end
    endcase
  end

  // Second timer next-state; mode three holds it
  always_comb begin
    slo_next = slo_reg;
    shi_next = shi_reg;
    s_ovf = 1'b0;
    case (smode)
      dtcu_pkg::MODE_13: begin
        slo_next = {3'h0, slo_reg[4:0]};
        if (s_run) begin
          {shi_next, slo_next[4:0]} = {shi_reg, slo_reg[4:0]} + 13'h1;
          s_ovf = (shi_reg == 8'hFF) && (slo_reg[4:0] == 5'h1F);
        end
      end
      dtcu_pkg::MODE_16: begin
        if (s_run) begin
          {shi_next, slo_next} = {shi_reg, slo_reg} + 16'h1;
          s_ovf = {shi_reg, slo_reg} == 16'hFFFF;
        end
      end
      dtcu_pkg::MODE_RELOAD: begin
        if (s_run) begin
          s_ovf = slo_reg == 8'hFF;
          slo_next = s_ovf ? shi_reg : slo_reg + 8'h01;
        end
      end
      default: begin
        slo_next = slo_reg;
      end
    endcase
  end

  // Count registers; software write takes priority over counting
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      flo_reg <= 8'h00;
      fhi_reg <= 8'h00;
      slo_reg <= 8'h00;
      shi_reg <= 8'h00;
    end else begin
      flo_reg <= (wr_en && waddr_reg == dtcu_pkg::ADDR_FLO) ? wdat : flo_next;
      fhi_reg <= (wr_en && waddr_reg == dtcu_pkg::ADDR_FHI) ? wdat : fhi_next;
      slo_reg <= (wr_en && waddr_reg == dtcu_pkg::ADDR_SLO) ? wdat : slo_next;
      shi_reg <= (wr_en && waddr_reg == dtcu_pkg::ADDR_SHI) ? wdat : shi_next;
    end
  end

  // Mode, prescaler, invert configuration
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      mode_reg <= dtcu_pkg::MODE_RESET;
      presc_reg <= dtcu_pkg::PRESC_RESET;
      inv_reg <= 1'b0;
    end else if (wr_en) begin
      if (waddr_reg == dtcu_pkg::ADDR_MODE) mode_reg <= wdat;
      if (waddr_reg == dtcu_pkg::ADDR_PRESC) presc_reg <= wdat[3:0];
      if (waddr_reg == dtcu_pkg::ADDR_INV) inv_reg <= wdat[dtcu_pkg::INV_BIT];
    end
  end

  // Service strobes from the invert register write (flag clear on service)
  assign svc_fovf = {wr_en && waddr_reg == dtcu_pkg::ADDR_INV
                     && wdat[dtcu_pkg::SVC_SOVF],
                     wr_en && waddr_reg == dtcu_pkg::ADDR_INV
                     && wdat[dtcu_pkg::SVC_FOVF]};
  assign svc_sovf = {wr_en && waddr_reg == dtcu_pkg::ADDR_INV
                     && wdat[dtcu_pkg::SVC_BFLAG],
                     wr_en && waddr_reg == dtcu_pkg::ADDR_INV
                     && wdat[dtcu_pkg::SVC_AFLAG]};

  // Control register: software write then hardware set; set wins
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctrl_reg <= dtcu_pkg::CTRL_RESET;
    end else begin
      logic [7:0] c;
      c = ctrl_reg;
      if (wr_en && waddr_reg == dtcu_pkg::ADDR_CTRL) c = wdat;
      if (svc_fovf[0]) c[dtcu_pkg::CTRL_FOVF] = 1'b0;
      if (svc_fovf[1]) c[dtcu_pkg::CTRL_SOVF] = 1'b0;
      if (svc_sovf[0]) c[dtcu_pkg::CTRL_AFLAG] = 1'b0;
      if (svc_sovf[1]) c[dtcu_pkg::CTRL_BFLAG] = 1'b0;
      if (f_ovf) c[dtcu_pkg::CTRL_FOVF] = 1'b1;
      // Split mode hands second flag to the high byte
      if (fmode == dtcu_pkg::MODE_SPLIT) begin
        if (hi_ovf) c[dtcu_pkg::CTRL_SOVF] = 1'b1;
      end else if (s_ovf) begin
        c[dtcu_pkg::CTRL_SOVF] = 1'b1;
      end
      if (a_trig) c[dtcu_pkg::CTRL_AFLAG] = 1'b1;
      if (b_trig) c[dtcu_pkg::CTRL_BFLAG] = 1'b1;
      ctrl_reg <= c;
    end
  end

  assign FIRST_OVERFLOW_O = ctrl_reg[dtcu_pkg::CTRL_FOVF];
  assign SECOND_OVERFLOW_O = ctrl_reg[dtcu_pkg::CTRL_SOVF];
  assign EXT_IRQ_A_O = ctrl_reg[dtcu_pkg::CTRL_AFLAG];
  assign EXT_IRQ_B_O = ctrl_reg[dtcu_pkg::CTRL_BFLAG];

  // Checks
  chk_ovf_sets_flag: assert property (@(posedge CLK_I) disable iff (RST_I)
    f_ovf |=> FIRST_OVERFLOW_O)
    else $error("overflow did not set first flag");
  chk_mode0_topbits: assert property (@(posedge CLK_I) disable iff (RST_I)
    (fmode == dtcu_pkg::MODE_13
     && !(wr_en && waddr_reg == dtcu_pkg::ADDR_FLO))
    |=> flo_reg[7:5] == 3'h0)
    else $error("mode zero upper bits not zero");
  chk_run_off_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    (!ctrl_reg[dtcu_pkg::CTRL_FRUN] && fmode == dtcu_pkg::MODE_16 && !wr_en)
    |=> $stable({fhi_reg, flo_reg}))
    else $error("first timer moved while stopped");
  chk_reload_value: assert property (@(posedge CLK_I) disable iff (RST_I)
    (fmode == dtcu_pkg::MODE_RELOAD && f_run && flo_reg == 8'hFF && !wr_en)
    |=> flo_reg == $past(fhi_reg))
    else $error("reload value wrong");
  chk_second_stop: assert property (@(posedge CLK_I) disable iff (RST_I)
    (smode == dtcu_pkg::MODE_SPLIT && !wr_en) |=> $stable(slo_reg))
    else $error("second timer moved in mode three");
  chk_gate_blocks: assert property (@(posedge CLK_I) disable iff (RST_I)
    (mode_reg[dtcu_pkg::MODE_GATE] && !EXT_IRQ_A_PIN_I) |-> !f_run)
    else $error("gate did not block first timer");
  chk_counter_edge: assert property (@(posedge CLK_I) disable iff (RST_I)
    (mode_reg[dtcu_pkg::MODE_CNT] && f_run)
    |-> $fell(FIRST_COUNT_INPUT_PIN_I))
    else $error("counter advanced without falling edge");
  chk_16_wrap: assert property (@(posedge CLK_I) disable iff (RST_I)
    (fmode == dtcu_pkg::MODE_16 && f_run && {fhi_reg, flo_reg} == 16'hFFFF
     && !wr_en) |=> {fhi_reg, flo_reg} == 16'h0000)
    else $error("sixteen bit wrap wrong");
  chk_split_hi_flag: assert property (@(posedge CLK_I) disable iff (RST_I)
    (fmode == dtcu_pkg::MODE_SPLIT && hi_ovf) |=> SECOND_OVERFLOW_O)
    else $error("split high byte flag missing");
  cov_mode13_ovf: cover property (@(posedge CLK_I)
    fmode == dtcu_pkg::MODE_13 && f_ovf);
  cov_reload: cover property (@(posedge CLK_I)
    smode == dtcu_pkg::MODE_RELOAD && s_ovf);
  cov_split: cover property (@(posedge CLK_I) hi_ovf && f_ovf);
  cov_ext_edge: cover property (@(posedge CLK_I)
    ctrl_reg[dtcu_pkg::CTRL_ATYPE] && a_trig);
endmodule

// file: dtcu_pin_model.sv
// Far-side model: count input pins and external interrupt pins.
// Assumes the bench calls its tasks; levels change after a rising edge.
`timescale 1ns/1ps
module dtcu_pin_model (
  input wire logic clk_i, // System clock
  output logic first_cnt_o, // First count input
  output logic second_cnt_o, // Second count input
  output logic irq_a_o, // Ext interrupt A and gate
  output logic irq_b_o // Ext interrupt B and gate
);
  // Idle high keeps gates open and low-level triggers quiet
  initial begin
    first_cnt_o = 1'b1;
    second_cnt_o = 1'b1;
    irq_a_o = 1'b1;
    irq_b_o = 1'b1;
  end

  // Each level held two clocks, never faster than the pin allows
  task automatic pulses(input int which, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge clk_i);
      if (which == 0) begin
        first_cnt_o <= i[0];
      end else begin
        second_cnt_o <= i[0];
      end
      @(posedge clk_i);
    end
  endtask

  // Interrupt pin levels, held a few clocks for the detector
  task automatic set_irq(input logic a, input logic b);
    @(posedge clk_i);
    irq_a_o <= a;
    irq_b_o <= b;
    repeat (3) @(posedge clk_i);
  endtask
endmodule

// file: tb.sv
// Self-checking bench for the dual timer/counter unit.
// Assumes a zero-wait AHB-Lite slave and the pin model beside it.
`timescale 1ns/1ps
module tb;
  logic clk, rst, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic hreadyout, hresp, fc, sc, ia, ib;
  logic fovf, sovf, aflg, bflg;
  logic [3:0] flags;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  assign flags = {bflg, aflg, sovf, fovf};

  dtcu_top dut_u (.CLK_I(clk), .RST_I(rst), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hreadyout),
    .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
    .FIRST_COUNT_INPUT_PIN_I(fc), .SECOND_COUNT_INPUT_PIN_I(sc),
    .EXT_IRQ_A_PIN_I(ia), .EXT_IRQ_B_PIN_I(ib),
    .FIRST_OVERFLOW_O(fovf), .SECOND_OVERFLOW_O(sovf),
    .EXT_IRQ_A_O(aflg), .EXT_IRQ_B_O(bflg));
  dtcu_pin_model pin_u (.clk_i(clk), .first_cnt_o(fc),
    .second_cnt_o(sc), .irq_a_o(ia), .irq_b_o(ib));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard, far above the longest expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One bus transfer: address phase, then data phase, each until ready
  task automatic xfer(input logic [9:0] a, input logic w,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {22'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata[7:0];
    @(negedge clk); // Outputs settled before any check
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(a, 1'b1, d, q);
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e,
                        input string nm);
    logic [7:0] q;
    xfer(a, 1'b0, 8'h00, q);
    check(nm, {24'h000000, q}, {24'h000000, e});
  endtask

  // Bounded wait on one of the four flag outputs
  task automatic wait_flag(input int idx, input int lim, output int k);
    k = 0;
    while (flags[idx] !== 1'b1 && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic t_reset_values();
    rd_chk(dtcu_pkg::ADDR_CTRL, 8'h00, "ctrl reset");
    rd_chk(dtcu_pkg::ADDR_MODE, 8'h00, "mode reset");
    rd_chk(dtcu_pkg::ADDR_PRESC, 8'h0F, "presc reset");
    check("okay response", hresp, 1'b0);
    rd_chk(10'h3F8, 8'h00, "unmapped read");
    wr(10'h3F8, 8'hFF);
    rd_chk(dtcu_pkg::ADDR_CTRL, 8'h00, "ctrl after stray");
  endtask

  // Sixteen-bit wrap: two /12 ticks from FFFE, then stop and clear
  task automatic t_mode_one();
    wr(dtcu_pkg::ADDR_MODE, 8'h01);
    wr(dtcu_pkg::ADDR_FHI, 8'hFF);
    wr(dtcu_pkg::ADDR_FLO, 8'hFE);
    wr(dtcu_pkg::ADDR_CTRL, 8'h10);
    wait_flag(0, 60, n);
    check("mode1 flag", fovf, 1'b1);
    check("mode1 two ticks", n >= 13 && n <= 24, 1'b1);
    wr(dtcu_pkg::ADDR_CTRL, 8'h00);
    check("flag clear by zero", fovf, 1'b0);
    rd_chk(dtcu_pkg::ADDR_FLO, 8'h00, "mode1 low wrap");
    rd_chk(dtcu_pkg::ADDR_FHI, 8'h00, "mode1 high wrap");
  endtask

  // Thirteen bits: top of low byte forced zero, one tick overflows
  task automatic t_mode_zero();
    wr(dtcu_pkg::ADDR_MODE, 8'h00);
    wr(dtcu_pkg::ADDR_FLO, 8'hFF);
    rd_chk(dtcu_pkg::ADDR_FLO, 8'h1F, "mode0 low top");
    wr(dtcu_pkg::ADDR_FHI, 8'hFF);
    wr(dtcu_pkg::ADDR_CTRL, 8'h10);
    wait_flag(0, 60, n);
    check("mode0 one tick", n >= 1 && n <= 12 && fovf === 1'b1, 1'b1);
    wr(dtcu_pkg::ADDR_CTRL, 8'h00);
    rd_chk(dtcu_pkg::ADDR_FLO, 8'h00, "mode0 low wrap");
    rd_chk(dtcu_pkg::ADDR_FHI, 8'h00, "mode0 high wrap");
  endtask

  // Reload on a divide-by-8 clock: two ticks from FE
  task automatic t_reload();
    wr(dtcu_pkg::ADDR_PRESC, 8'h0E);
    wr(dtcu_pkg::ADDR_MODE, 8'h02);
    wr(dtcu_pkg::ADDR_FHI, 8'hA0);
    wr(dtcu_pkg::ADDR_FLO, 8'hFE);
    wr(dtcu_pkg::ADDR_CTRL, 8'h10);
    wait_flag(0, 60, n);
    wr(dtcu_pkg::ADDR_CTRL, 8'h00);
    check("reload flag time", n >= 9 && n <= 16, 1'b1);
    rd_chk(dtcu_pkg::ADDR_FLO, 8'hA0, "reload low");
    rd_chk(dtcu_pkg::ADDR_FHI, 8'hA0, "reload high kept");
  endtask

  // Gated counter: edges ignored while gate pin low, counted when high
  task automatic t_counter_gate();
    wr(dtcu_pkg::ADDR_MODE, 8'h0D);
    wr(dtcu_pkg::ADDR_FLO, 8'h00);
    wr(dtcu_pkg::ADDR_FHI, 8'h00);
    wr(dtcu_pkg::ADDR_CTRL, 8'h10);
    pin_u.set_irq(1'b0, 1'b1);
    check("low level flag", aflg, 1'b1);
    pin_u.pulses(0, 3);
    rd_chk(dtcu_pkg::ADDR_FLO, 8'h00, "gated count");
    pin_u.set_irq(1'b1, 1'b1);
    wr(dtcu_pkg::ADDR_INV, 8'h10);
    check("service clears A", aflg, 1'b0);
    pin_u.pulses(0, 3);
    rd_chk(dtcu_pkg::ADDR_FLO, 8'h03, "edge count");
    wr(dtcu_pkg::ADDR_CTRL, 8'h00);
  endtask

  // Split: high byte runs on second run bit, second timer frozen
  task automatic t_split();
    wr(dtcu_pkg::ADDR_PRESC, 8'h05);
    wr(dtcu_pkg::ADDR_MODE, 8'h33);
    wr(dtcu_pkg::ADDR_SLO, 8'h10);
    wr(dtcu_pkg::ADDR_FLO, 8'hFF);
    wr(dtcu_pkg::ADDR_FHI, 8'hFE);
    wr(dtcu_pkg::ADDR_CTRL, 8'h40);
    wait_flag(1, 40, n);
    check("split high flag", n >= 5 && n <= 8 && sovf === 1'b1, 1'b1);
    check("split low idle", fovf, 1'b0);
    rd_chk(dtcu_pkg::ADDR_SLO, 8'h10, "second stopped");
    wr(dtcu_pkg::ADDR_INV, 8'h08);
    check("service clears second", sovf, 1'b0);
    wr(dtcu_pkg::ADDR_CTRL, 8'h10);
    wait_flag(0, 40, n);
    check("split low flag", n >= 1 && n <= 4 && fovf === 1'b1, 1'b1);
    wr(dtcu_pkg::ADDR_INV, 8'h04);
    check("service clears first", fovf, 1'b0);
    // Second timer counts edges beside split; its flag stays quiet
    wr(dtcu_pkg::ADDR_MODE, 8'h63);
    wr(dtcu_pkg::ADDR_SLO, 8'hFE);
    wr(dtcu_pkg::ADDR_FHI, 8'h00);
    wr(dtcu_pkg::ADDR_CTRL, 8'h40);
    pin_u.pulses(1, 3);
    check("split keeps second flag", sovf, 1'b0);
    rd_chk(dtcu_pkg::ADDR_SLO, 8'h01, "second edge count");
    wr(dtcu_pkg::ADDR_CTRL, 8'h00);
  endtask

  // Edge triggers with and without inversion, both pins
  task automatic t_ext_trigger();
    // Edge types first: inverted level mode fires on idle-high pins
    wr(dtcu_pkg::ADDR_CTRL, 8'h05);
    wr(dtcu_pkg::ADDR_INV, 8'h32);
    rd_chk(dtcu_pkg::ADDR_INV, 8'h02, "invert readback");
    pin_u.set_irq(1'b0, 1'b0);
    check("falling ignored", flags[3:2], 2'b00);
    pin_u.set_irq(1'b1, 1'b1);
    check("rising sets", flags[3:2], 2'b11);
    wr(dtcu_pkg::ADDR_INV, 8'h30);
    check("service clears", flags[3:2], 2'b00);
    pin_u.set_irq(1'b0, 1'b0);
    check("falling sets", flags[3:2], 2'b11);
    rd_chk(dtcu_pkg::ADDR_CTRL, 8'h0F, "ctrl flags");
    pin_u.set_irq(1'b1, 1'b1);
  endtask

  // Main sequence: reset held six clocks, then each scenario
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_mode_one();
    t_mode_zero();
    t_reload();
    t_counter_gate();
    t_split();
    t_ext_trigger();
    tally_and_finish();
  end
endmodule
